// >>> inc/asr_consts.vh
// Constants for the converter status register block: offsets, field positions,
// reset values and serial frame lengths.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH

// ----------------------------------------------------------------------------
// Register select codes carried in register_select_bits of the comms byte
// ----------------------------------------------------------------------------
`define ASR_ADDR_STATUS        6'h00
`define ASR_ADDR_DATA          6'h04

// ----------------------------------------------------------------------------
// Status register layout and reset value
// ----------------------------------------------------------------------------
`define ASR_STATUS_RESET       8'h80
`define ASR_BIT_READY          7
`define ASR_BIT_RANGE_ERR      6
`define ASR_BIT_WCHK_ERR       5
`define ASR_BIT_INTEG_ERR      4
`define ASR_CHAN_MSB           3
`define ASR_CHAN_LSB           0

// ----------------------------------------------------------------------------
// Comms byte fields
// ----------------------------------------------------------------------------
`define ASR_COMM_WEN_N         7
`define ASR_COMM_READ          6
`define ASR_SEL_MSB            5
`define ASR_SEL_LSB            0

// ----------------------------------------------------------------------------
// Data register values and serial frame lengths in bits
// ----------------------------------------------------------------------------
`define ASR_DATA_RESET         24'h000000
`define ASR_DATA_ALL_ONES      24'hFFFFFF
`define ASR_DATA_ALL_ZEROS     24'h000000
`define ASR_LEN_BYTE           6'h08
`define ASR_LEN_DATA           6'h18
`define ASR_LEN_DATA_STAT      6'h20

`endif

// >>> logic/asr_pin_sync.v
// Two-flop synchroniser for one pin input, with edge pulses on the clean side.
// Assumes the pin is asynchronous to CLOCK and changes slower than CLOCK.
`timescale 1ns/10ps
`default_nettype none

module asr_pin_sync (
  input  wire CLOCK,
  input  wire RESET_N,
  input  wire pin_in,
  output wire level,
  output wire rise,
  output wire fall
);

  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  // ----------------------------------------------------------------------------
  // Synchroniser chain; the first flop feeds only the second
  // ----------------------------------------------------------------------------
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges found on the settled stages only
  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;

endmodule // asr_pin_sync

`default_nettype wire

// >>> logic/asr_status_top.v
// Converter status register with its serial read path and ready indication.
// Assumes a mode-3 serial host (clock idles high, device shifts on the falling
// edge, host samples on the rising edge) and conversion logic on CLOCK that
// reports results, calibration ends, checksum failures and integrity mismatches.
//
// Function
// - An eight-bit status register resets to 0x80, only the ready flag set.
// - With append-status set, a data register read sends the status byte after the result.
// - With chip select low and no read running, the data-out pin shows the ready flag.
// - The ready flag drops to 0 when a new result lands in the data register.
// - In calibration mode the ready flag drops when the calibration result is written instead.
// - A host read of the data register raises the ready flag back to 1, unless a new result lands in the same cycle.
// - Bit 6 flags an overrange or underrange of the conversion.
// - Overrange saturates the stored result at all ones, underrange at all zeros.
// - The range flag changes only when a result is written and clears on the next good one.
// - Bit 5 is set when a register write fails its checksum; reads are checked by the host.
// - Reading the status register clears the write check flag.
// - With integrity checking on, bit 4 sets when register contents no longer match.
// - The integrity flag holds until the host clears the check enable, which clears it.
// - Bits 3 to 0 give the channel of the result now held in the data register.
`timescale 1ns/10ps
`default_nettype none
`include "asr_consts.vh"

module asr_status_top (
  input  wire        CLOCK,
  input  wire        RESET_N,
  input  wire        SCLK,
  input  wire        CS_N,
  input  wire        DIN,
  output wire        DOUT_RDY,
  output wire        DOUT_RDY_OE_N,
  input  wire        APPEND_STATUS,
  input  wire        REG_CHECK_EN,
  input  wire        REG_MISMATCH,
  input  wire        WRITE_CRC_FAIL,
  input  wire        CAL_MODE,
  input  wire        CAL_DONE,
  input  wire        RESULT_VALID,
  input  wire [23:0] RESULT_DATA,
  input  wire [3:0]  RESULT_CHANNEL,
  input  wire        OVERRANGE,
  input  wire        UNDERRANGE,
  output wire [7:0]  STATUS,
  output wire [23:0] DATA_WORD
);

  // ----------------------------------------------------------------------------
  // Serial frame states
  // ----------------------------------------------------------------------------
  localparam [1:0] ST_COMM  = 2'b00;
  localparam [1:0] ST_READ  = 2'b01;
  localparam [1:0] ST_WRITE = 2'b10;

  wire        sclk_rise;
  wire        sclk_fall;
  wire        cs_n_lvl;
  wire        din_lvl;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [5:0]  bit_cnt_reg;
  reg  [5:0]  bit_cnt_next;
  reg  [5:0]  len_reg;
  reg  [5:0]  len_next;
  reg  [6:0]  comm_reg;
  reg  [6:0]  comm_next;
  reg  [31:0] tx_reg;
  reg  [31:0] tx_next;
  reg         dout_reg;
  reg         dout_next;
  reg         rd_status_reg;
  reg         rd_status_next;
  reg         data_read_pulse;
  reg         status_read_pulse;

  reg         ready_reg;
  reg         range_err_reg;
  reg         wchk_err_reg;
  reg         integ_err_reg;
  reg  [3:0]  chan_reg;
  reg  [23:0] data_reg;

  wire [7:0]  comm_byte;
  wire [7:0]  status_byte;
  wire        new_data;
  // Reset image of the register, split per field so no bits are dropped
  wire [7:0]  status_reset = `ASR_STATUS_RESET;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  asr_pin_sync u_sync_sclk (
    .CLOCK   (CLOCK),
    .RESET_N (RESET_N),
    .pin_in  (SCLK),
    .level   (),
    .rise    (sclk_rise),
    .fall    (sclk_fall)
  );

  asr_pin_sync u_sync_cs (
    .CLOCK   (CLOCK),
    .RESET_N (RESET_N),
    .pin_in  (CS_N),
    .level   (cs_n_lvl),
    .rise    (),
    .fall    ()
  );

  asr_pin_sync u_sync_din (
    .CLOCK   (CLOCK),
    .RESET_N (RESET_N),
    .pin_in  (DIN),
    .level   (din_lvl),
    .rise    (),
    .fall    ()
  );

  // Status byte assembled from the flags
  assign status_byte = {ready_reg, range_err_reg, wchk_err_reg, integ_err_reg, chan_reg};
  assign comm_byte   = {comm_reg, din_lvl};
  // Calibration modes signal completion instead of a stored result
  assign new_data    = CAL_MODE ? CAL_DONE : RESULT_VALID;

  // ----------------------------------------------------------------------------
  // Serial frame decoder and shifter
  // ----------------------------------------------------------------------------
  always @* begin
    state_next        = state_reg;
    bit_cnt_next      = bit_cnt_reg;
    len_next          = len_reg;
    comm_next         = comm_reg;
    tx_next           = tx_reg;
    dout_next         = dout_reg;
    rd_status_next    = rd_status_reg;
    data_read_pulse   = 1'b0;
    status_read_pulse = 1'b0;
    if (cs_n_lvl) begin
      // Deselect abandons any partial transfer
      state_next   = ST_COMM;
      bit_cnt_next = 6'h00;
    end else begin
      case (state_reg)
        ST_COMM: begin
          if (sclk_rise) begin
            comm_next    = comm_byte[6:0];
            bit_cnt_next = bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == (`ASR_LEN_BYTE - 6'h01)) begin
              bit_cnt_next = 6'h00;
              // A comms byte with its enable bit high is not a command
              if (!comm_byte[`ASR_COMM_WEN_N]) begin
                if (comm_byte[`ASR_COMM_READ]) begin
                  state_next     = ST_READ;
                  rd_status_next = 1'b0;
                  if (comm_byte[`ASR_SEL_MSB:`ASR_SEL_LSB] == `ASR_ADDR_STATUS) begin
                    tx_next        = {status_byte, 24'h000000};
                    len_next       = `ASR_LEN_BYTE;
                    rd_status_next = 1'b1;
                  end else if (comm_byte[`ASR_SEL_MSB:`ASR_SEL_LSB] == `ASR_ADDR_DATA) begin
                    // Snapshot keeps the word steady while new results arrive
                    tx_next         = {data_reg, status_byte};
                    len_next        = APPEND_STATUS ? `ASR_LEN_DATA_STAT : `ASR_LEN_DATA;
                    data_read_pulse = 1'b1;
                  end else begin
                    tx_next  = 32'h00000000;
                    len_next = `ASR_LEN_BYTE;
                  end
                end else begin
                  // Writes are swallowed; no flag is writable here
                  state_next = ST_WRITE;
                end
              end
            end
          end
        end
        ST_READ: begin
          if (sclk_fall) begin
            dout_next = tx_reg[31];
            tx_next   = {tx_reg[30:0], 1'b0};
          end
          if (sclk_rise) begin
            bit_cnt_next = bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == (len_reg - 6'h01)) begin
              state_next        = ST_COMM;
              bit_cnt_next      = 6'h00;
              status_read_pulse = rd_status_reg;
            end
          end
        end
        ST_WRITE: begin
          if (sclk_rise) begin
            bit_cnt_next = bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == (`ASR_LEN_BYTE - 6'h01)) begin
              state_next   = ST_COMM;
              bit_cnt_next = 6'h00;
            end
          end
        end
        default: begin
          state_next   = ST_COMM;
          bit_cnt_next = 6'h00;
        end
      endcase
    end
  end

  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_reg     <= ST_COMM;
      bit_cnt_reg   <= 6'h00;
      len_reg       <= `ASR_LEN_BYTE;
      comm_reg      <= 7'h00;
      tx_reg        <= 32'h00000000;
      dout_reg      <= 1'b1;
      rd_status_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      bit_cnt_reg   <= bit_cnt_next;
      len_reg       <= len_next;
      comm_reg      <= comm_next;
      tx_reg        <= tx_next;
      dout_reg      <= dout_next;
      rd_status_reg <= rd_status_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Status flags and data register
  // ----------------------------------------------------------------------------
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      ready_reg     <= status_reset[`ASR_BIT_READY];
      range_err_reg <= status_reset[`ASR_BIT_RANGE_ERR];
      wchk_err_reg  <= status_reset[`ASR_BIT_WCHK_ERR];
      integ_err_reg <= status_reset[`ASR_BIT_INTEG_ERR];
      chan_reg      <= status_reset[`ASR_CHAN_MSB:`ASR_CHAN_LSB];
      data_reg      <= `ASR_DATA_RESET;
    end else begin
      // A fresh result outranks a read, since the read carried the old word
      if (new_data)
        ready_reg <= 1'b0;
      else if (data_read_pulse)
        ready_reg <= 1'b1;
      // Range flag and saturation move only with a stored result
      if (RESULT_VALID && !CAL_MODE) begin
        range_err_reg <= OVERRANGE | UNDERRANGE;
        chan_reg      <= RESULT_CHANNEL;
        if (OVERRANGE)
          data_reg <= `ASR_DATA_ALL_ONES;
        else if (UNDERRANGE)
          data_reg <= `ASR_DATA_ALL_ZEROS;
        else
          data_reg <= RESULT_DATA;
      end
      // Checksum failure wins over a clearing read in the same cycle
      if (WRITE_CRC_FAIL)
        wchk_err_reg <= 1'b1;
      else if (status_read_pulse)
        wchk_err_reg <= 1'b0;
      // Integrity flag sticks until the check is switched off
      if (!REG_CHECK_EN)
        integ_err_reg <= 1'b0;
      else if (REG_MISMATCH)
        integ_err_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin and observation outputs
  // ----------------------------------------------------------------------------
  // Mux kept combinational: a registered pin would eat the half clock the host needs
  assign DOUT_RDY      = (state_reg == ST_READ) ? dout_reg : ready_reg;
  assign DOUT_RDY_OE_N = cs_n_lvl;
  assign STATUS        = status_byte;
  assign DATA_WORD     = data_reg;

endmodule // asr_status_top

`default_nettype wire

// >>> sim/asr_host_model.sv
// Serial host model driving the converter's four-wire port in mode 3.
// Assumes the bench calls its tasks; clock idles high, device shifts on fall.
`timescale 1ns/10ps
`default_nettype none
module asr_host_model (
  output var logic SCLK,
  output var logic CS_N,
  output var logic DIN,
  input  wire      DOUT_RDY
);
  // ------------------------------------------------------------
  // Pin idle levels and bit timing, 400 ns per serial clock
  // ------------------------------------------------------------
  initial begin
    SCLK = 1'b1;
    CS_N = 1'b1;
    DIN  = 1'b1;
  end

  // Data changes on the fall so both sides see it settled at the rise
  task automatic bit_x(input logic b, output logic r);
    SCLK = 1'b0;
    DIN  = b;
    #200;
    SCLK = 1'b1;
    r = DOUT_RDY;
    #200;
  endtask

  // Comms byte then n bits; odd offset keeps link edges off CLOCK edges
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wr, input int n, output logic [31:0] rd);
    logic r;
    rd = 32'h00000000;
    #13;
    CS_N = 1'b0;
    #400;
    for (int i = 7; i >= 0; i--) bit_x(cmd[i], r);
    for (int i = n - 1; i >= 0; i--) begin
      bit_x(cmd[6] ? ~DIN : wr[i], r);
      rd = {rd[30:0], r};
    end
    #400;
    CS_N = 1'b1;
    DIN  = ~DIN; // Released line must not keep a stale value
    #400;
  endtask

  // Select without clocking to watch the ready level on the pin
  task automatic peek(output logic r);
    #13;
    CS_N = 1'b0;
    #600;
    r = DOUT_RDY;
    CS_N = 1'b1;
    #400;
  endtask
endmodule // asr_host_model
`default_nettype wire

// >>> sim/asr_status_sva.sv
// Checker for the status register block, bound to its top module ports.
// Assumes synchronous active-low reset on CLOCK.
`timescale 1ns/10ps
`default_nettype none
module asr_status_sva (
  input wire        CLOCK,
  input wire        RESET_N,
  input wire        CS_N,
  input wire        DOUT_RDY_OE_N,
  input wire        REG_CHECK_EN,
  input wire        REG_MISMATCH,
  input wire        WRITE_CRC_FAIL,
  input wire        CAL_MODE,
  input wire        CAL_DONE,
  input wire        RESULT_VALID,
  input wire [23:0] RESULT_DATA,
  input wire [3:0]  RESULT_CHANNEL,
  input wire        OVERRANGE,
  input wire        UNDERRANGE,
  input wire [7:0]  STATUS,
  input wire [23:0] DATA_WORD
);
  // ------------------------------------------------------------
  // Properties for reset, results, flags and pin enable; read-driven flag changes are not checked
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  property p_rst; $rose(RESET_N) |-> STATUS == 8'h80 && DATA_WORD == 24'h000000; endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_rdy; RESULT_VALID && !CAL_MODE |=> !STATUS[7]; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not cleared");
  property p_cal; CAL_MODE && CAL_DONE |=> !STATUS[7]; endproperty
  a_cal: assert property (p_cal) else $error("ready not cleared by cal");
  property p_ovr; RESULT_VALID && !CAL_MODE && OVERRANGE |=> DATA_WORD == 24'hFFFFFF && STATUS[6]; endproperty
  a_ovr: assert property (p_ovr) else $error("overrange not saturated");
  property p_und; RESULT_VALID && !CAL_MODE && UNDERRANGE && !OVERRANGE |=> DATA_WORD == 24'h000000 && STATUS[6];
  endproperty
  a_und: assert property (p_und) else $error("underrange not saturated");
  property p_good; RESULT_VALID && !CAL_MODE && !OVERRANGE && !UNDERRANGE |=> !STATUS[6]
    && DATA_WORD == $past(RESULT_DATA) && STATUS[3:0] == $past(RESULT_CHANNEL); endproperty
  a_good: assert property (p_good) else $error("result or channel wrong");
  property p_hold; !(RESULT_VALID && !CAL_MODE) |=> $stable(STATUS[6]) && $stable(DATA_WORD); endproperty
  a_hold: assert property (p_hold) else $error("range flag moved");
  property p_wchk; WRITE_CRC_FAIL |=> STATUS[5]; endproperty
  a_wchk: assert property (p_wchk) else $error("write check flag not set");
  property p_iset; REG_CHECK_EN && REG_MISMATCH |=> STATUS[4]; endproperty
  a_iset: assert property (p_iset) else $error("integrity flag not set");
  property p_iclr; !REG_CHECK_EN |=> !STATUS[4]; endproperty
  a_iclr: assert property (p_iclr) else $error("integrity flag not cleared");
  property p_oe; CS_N [*4] |-> DOUT_RDY_OE_N; endproperty
  a_oe: assert property (p_oe) else $error("pin driven while deselected");
  property p_sel; !CS_N [*4] |-> !DOUT_RDY_OE_N; endproperty
  a_sel: assert property (p_sel) else $error("pin not driven while selected");
endmodule // asr_status_sva
bind asr_status_top asr_status_sva chk (.*);
`default_nettype wire

// >>> sim/asr_status_top_tb_top.sv
// Self-checking bench for the status register block.
// Assumes the host model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch %0t got %h exp %h", $time, a, e); end end
module asr_status_top_tb_top;
  logic        CLOCK, RESET_N, SCLK, CS_N, DIN, DOUT_RDY, DOUT_RDY_OE_N, r;
  logic        APPEND_STATUS, REG_CHECK_EN, REG_MISMATCH, WRITE_CRC_FAIL, CAL_MODE, CAL_DONE;
  logic        RESULT_VALID, OVERRANGE, UNDERRANGE;
  logic [23:0] RESULT_DATA, DATA_WORD, d;
  logic [3:0]  RESULT_CHANNEL;
  logic [7:0]  STATUS, st;
  logic [31:0] obs, rd, rnd, exp_v;
  logic [31:0] expq[$];
  int          mismatches, samples_checked;
  event        seen;

  // ------------------------------------------------------------
  // Clock, design, host
  // ------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  asr_status_top uut (.*);
  asr_host_model host (.*);

  // Note the expectation, then hand over the observed value
  task automatic expect_v(input logic [31:0] e, input logic [31:0] a);
    expq.push_back(e);
    obs = a;
    ->seen;
    #1;
  endtask

  // Oldest note against the latest observation
  // Popped once, so a mismatch report cannot eat a second note
  always @(seen) begin
    exp_v = expq.pop_front();
    `CHK(obs, exp_v)
  end

  // One converter result; expected register image tracked in st and d
  task automatic result(input logic ov, input logic un);
    rnd = $urandom;
    @(posedge CLOCK);
    RESULT_VALID   <= 1'b1;
    RESULT_DATA    <= rnd[23:0];
    RESULT_CHANNEL <= rnd[27:24];
    OVERRANGE      <= ov;
    UNDERRANGE     <= un;
    @(posedge CLOCK) RESULT_VALID <= 1'b0;
    @(posedge CLOCK);
    #1;
    d  = ov ? 24'hFFFFFF : (un ? 24'h000000 : rnd[23:0]);
    st = {1'b0, ov | un, st[5:4], rnd[27:24]};
  endtask

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard
  initial begin
    #2000000;
    mismatches++;
    end_sim;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {APPEND_STATUS, REG_CHECK_EN, REG_MISMATCH, WRITE_CRC_FAIL, CAL_MODE, CAL_DONE} = 6'h00;
    {RESULT_VALID, OVERRANGE, UNDERRANGE} = 3'h0;
    RESULT_DATA = 24'h000000;
    RESULT_CHANNEL = 4'h0;
    RESET_N = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    rnd = $urandom(32'h8676);
    repeat (4) @(posedge CLOCK);
    RESET_N <= 1'b1;
    repeat (4) @(posedge CLOCK);
    #1;
    st = 8'h80;
    expect_v({24'h000000, st}, {24'h000000, STATUS});
    host.xfer(8'h40, 8'h00, 8, rd);
    expect_v({24'h000000, st}, rd);
    $display("reset test done");
    // Normal, over, under, normal again; append on odd passes
    for (int i = 0; i < 4; i++) begin
      @(posedge CLOCK) APPEND_STATUS <= i[0];
      result(i == 1, i == 2);
      host.peek(r);
      expect_v(32'h00000000, {31'h0, r});
      expect_v({st, d}, {STATUS, DATA_WORD});
      host.xfer(8'h44, 8'h00, i[0] ? 32 : 24, rd);
      expect_v(i[0] ? {d, st} : {8'h00, d}, rd);
      st[7] = 1'b1;
      host.peek(r);
      expect_v(32'h00000001, {31'h0, r});
    end
    $display("result test done");
    @(posedge CLOCK) CAL_MODE <= 1'b1;
    @(posedge CLOCK) CAL_DONE <= 1'b1;
    @(posedge CLOCK) CAL_DONE <= 1'b0;
    @(posedge CLOCK) CAL_MODE <= 1'b0;
    #1;
    st[7] = 1'b0;
    expect_v({24'h000000, st}, {24'h000000, STATUS});
    $display("calibration test done");
    @(posedge CLOCK) WRITE_CRC_FAIL <= 1'b1;
    @(posedge CLOCK) WRITE_CRC_FAIL <= 1'b0;
    st[5] = 1'b1;
    host.xfer(8'h00, 8'hFF, 8, rd); // Write aimed at the read-only register
    expect_v({24'h000000, st}, {24'h000000, STATUS});
    host.xfer(8'h40, 8'h00, 8, rd);
    expect_v({24'h000000, st}, rd);
    st[5] = 1'b0;
    expect_v({24'h000000, st}, {24'h000000, STATUS});
    host.xfer(8'h47, 8'h00, 8, rd);
    expect_v(32'h00000000, rd);
    // Comms byte with its enable bit high is refused; the pin keeps showing ready
    host.xfer(8'hC0, 8'h00, 8, rd);
    expect_v({24'h000000, {8{st[7]}}}, rd);
    expect_v({24'h000000, st}, {24'h000000, STATUS});
    $display("write check test done");
    @(posedge CLOCK) REG_CHECK_EN <= 1'b1;
    @(posedge CLOCK) REG_MISMATCH <= 1'b1;
    @(posedge CLOCK) REG_MISMATCH <= 1'b0;
    repeat (3) @(posedge CLOCK);
    #1;
    st[4] = 1'b1;
    expect_v({24'h000000, st}, {24'h000000, STATUS});
    @(posedge CLOCK) REG_CHECK_EN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    #1;
    st[4] = 1'b0;
    expect_v({24'h000000, st}, {24'h000000, STATUS});
    $display("integrity test done");
    end_sim;
  end
endmodule // asr_status_top_tb_top
`default_nettype wire
